// ==== hdl/static_bus_defs.svh ====
// Constants for the static memory bus engine and boot select decode
`ifndef STATIC_BUS_DEFS_SVH
`define STATIC_BUS_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SB_ADDR_W        26
`define SB_DATA_W        32
`define SB_NUM_CS        6
`define SB_CS_IDX_W      3
`define SB_BOOT_W        3

// ----------------------------------------------------------------
// Boot select codes (pin 2, pin 1, pin 0)
// ----------------------------------------------------------------
`define SB_BOOT_ASYNC32  3'h0
`define SB_BOOT_ASYNC16  3'h1
`define SB_BOOT_FLASH32  3'h2
`define SB_BOOT_FLASH16  3'h3
`define SB_BOOT_MROM32   3'h4
`define SB_BOOT_MROM16L  3'h5
`define SB_BOOT_MROMPAIR 3'h6
`define SB_BOOT_MROM16S  3'h7

// ----------------------------------------------------------------
// Capacity codes
// ----------------------------------------------------------------
`define SB_CAP_NONE      2'h0
`define SB_CAP_32MBIT    2'h1
`define SB_CAP_64MBIT    2'h2

// ----------------------------------------------------------------
// Timing counts in clock cycles, then the boot chip select and the held address bit value
// ----------------------------------------------------------------
`define SB_STROBE_CYC    3'h2
`define SB_REFRESH_CYC   3'h4
`define SB_BOOT_SETTLE   2'h3
`define SB_BOOT_CS       3'h0
`define SB_HELD_BIT      1'b0

`endif

// ==== hdl/static_bus_pkg.sv ====
// Types shared by the static memory bus engine
`include "static_bus_defs.svh"
package static_bus_pkg;

	typedef enum logic [1:0] {
		BOOT_ASYNC_ROM,
		BOOT_SYNC_FLASH,
		BOOT_SYNC_MASK_ROM
	} boot_kind_e;

	typedef struct packed {
		boot_kind_e kind;
		logic       width16;   // Bus width 16 when set, else 32
		logic       paired;    // Two 16-bit parts forming a 32-bit bus
		logic [1:0] capacity;
	} boot_cfg_s;

	typedef struct packed {
		logic                      write;
		logic [`SB_CS_IDX_W-1:0]   cs;
		logic [`SB_ADDR_W-1:0]     addr;
		logic [`SB_DATA_W-1:0]     wdata;
	} bus_req_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_REFRESH
	} bus_state_e;

endpackage

// ==== hdl/pin_sync.sv ====
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,    // System clock
	input  wire logic         rst_n_in,  // Asynchronous reset, active low
	input  wire logic [W-1:0] d_in,      // Asynchronous pin level
	output logic      [W-1:0] q_out      // Synchronised level
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= '0;
			q_out  <= '0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/static_bus_ctrl.sv ====
// Static memory bus engine: boot select decode, address masking, VLIO cycles
// Functional notes
// - Three boot pins give eight options; codes 0-3 async ROM 32/16, sync flash 32/16.
// - Code 4 selects 32-bit sync mask ROM, 64 Mbit.
// - Code 5 selects 16-bit mask ROM 64 Mbit; code 7 16-bit 32 Mbit.
// - Code 6 selects paired 16-bit mask ROMs, 32-bit wide, 64 Mbit.
// - On a 16-bit bus address bit 0 stays constant.
// - On a 32-bit bus address bits 1 and 0 stay constant.
// - VLIO chip selects stretch the strobe while ready is low.
// - Refresh cycles keep using the memory write strobe.
// - VLIO writes strobe the card write pin, not the memory one.
`timescale 1ns/1ps
`default_nettype none
`include "static_bus_defs.svh"
module static_bus_ctrl (
	input  wire logic                           clk_in,                 // 50 MHz clock
	input  wire logic                           rst_n_in,               // Async reset, active low
	input  wire logic [`SB_BOOT_W-1:0]          boot_sel_in,            // Boot select pins
	input  wire logic                           rdy_in,                 // Ready pin, high = ready
	input  wire logic [`SB_NUM_CS-1:0]          cs_vlio_in,             // Per-CS variable latency I/O
	input  wire logic [`SB_NUM_CS-1:0]          cs_width16_in,          // Per-CS 16-bit bus (CS0 ignored)
	input  wire logic                           req_valid_in,           // Access request
	input  wire static_bus_pkg::bus_req_s       req_in,                 // Access request fields
	output logic                                req_ready_out,          // Request taken this cycle
	input  wire logic                           refresh_req_in,         // Refresh request level
	output logic                                refresh_done_out,       // Refresh finished pulse
	output logic                                rsp_valid_out,          // Access finished pulse
	output logic [`SB_DATA_W-1:0]               rsp_rdata_out,          // Read data
	output static_bus_pkg::boot_cfg_s           boot_cfg_out,           // Decoded boot device
	output logic                                boot_valid_out,         // Boot decode is locked
	output logic [`SB_ADDR_W-1:0]               addr_out,               // Address pins
	output logic [`SB_NUM_CS-1:0]               cs_n_out,               // Chip selects, active low
	output logic                                oe_n_out,               // Output enable, active low
	output logic                                memory_write_strobe_n,  // Memory write strobe
	output logic                                card_write_strobe_n,    // Card write strobe
	input  wire logic [`SB_DATA_W-1:0]          data_in,                // Data pins in
	output logic [`SB_DATA_W-1:0]               data_out,               // Data pins out
	output logic                                data_oe_n_out           // Data drive enable, low drives
);
	import static_bus_pkg::*;

	logic [`SB_BOOT_W-1:0]   boot_sel_s;
	logic                    rdy_s;
	logic [`SB_DATA_W-1:0]   data_s;
	logic [1:0]              settle_q;
	logic [`SB_BOOT_W-1:0]   code_q;
	boot_cfg_s               boot_cfg_q;
	logic                    lock_q;
	bus_state_e              state_q;
	logic [2:0]              cnt_q;
	logic                    write_q;
	logic                    vlio_q;
	logic                    w16_q;
	logic [`SB_CS_IDX_W-1:0] cs_q;
	logic [`SB_ADDR_W-1:0]   addr_q;
	logic [`SB_DATA_W-1:0]   wdata_q;
	logic [`SB_DATA_W-1:0]   rdata_q;
	logic                    rsp_q;
	logic                    rfd_q;
	logic                    sel_w16;
	logic                    take_req;
	logic                    take_rfs;
	logic                    strobe_done;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	pin_sync #(.W(`SB_BOOT_W)) u_boot_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.d_in     (boot_sel_in),
		.q_out    (boot_sel_s)
	);

	pin_sync #(.W(1)) u_rdy_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.d_in     (rdy_in),
		.q_out    (rdy_s)
	);

	// Read data passes the synchroniser too; adds two cycles of sampling lag
	pin_sync #(.W(`SB_DATA_W)) u_data_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.d_in     (data_in),
		.q_out    (data_s)
	);

	// ----------------------------------------------------------------
	// Boot select decode
	// ----------------------------------------------------------------
	function automatic boot_cfg_s decode_boot(input logic [`SB_BOOT_W-1:0] code);
		boot_cfg_s c;
		c = '{kind: BOOT_ASYNC_ROM, width16: 1'b0, paired: 1'b0, capacity: `SB_CAP_NONE};
		case (code)
			`SB_BOOT_ASYNC32: c.kind = BOOT_ASYNC_ROM;
			`SB_BOOT_ASYNC16: begin
				c.kind    = BOOT_ASYNC_ROM;
				c.width16 = 1'b1;
			end
			`SB_BOOT_FLASH32: c.kind = BOOT_SYNC_FLASH;
			`SB_BOOT_FLASH16: begin
				c.kind    = BOOT_SYNC_FLASH;
				c.width16 = 1'b1;
			end
			`SB_BOOT_MROM32: begin
				c.kind     = BOOT_SYNC_MASK_ROM;
				c.capacity = `SB_CAP_64MBIT;
			end
			`SB_BOOT_MROM16L: begin
				c.kind     = BOOT_SYNC_MASK_ROM;
				c.width16  = 1'b1;
				c.capacity = `SB_CAP_64MBIT;
			end
			`SB_BOOT_MROMPAIR: begin
				c.kind     = BOOT_SYNC_MASK_ROM;
				c.paired   = 1'b1;
				c.capacity = `SB_CAP_64MBIT;
			end
			default: begin
				c.kind     = BOOT_SYNC_MASK_ROM;
				c.width16  = 1'b1;
				c.capacity = `SB_CAP_32MBIT;
			end
		endcase
		return c;
	endfunction

	// Pins are caught after release, once the synchroniser holds a clean copy
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_q   <= 2'h0;
			lock_q     <= 1'b0;
			code_q     <= `SB_BOOT_ASYNC32;
			boot_cfg_q <= '0;
		end else if (!lock_q) begin
			if (settle_q == `SB_BOOT_SETTLE) begin
				lock_q     <= 1'b1;
				code_q     <= boot_sel_s;
				boot_cfg_q <= decode_boot(boot_sel_s);
			end else begin
				settle_q <= settle_q + 2'h1;
			end
		end
	end

	assign boot_cfg_out   = boot_cfg_q;
	assign boot_valid_out = lock_q;

	// ----------------------------------------------------------------
	// Request acceptance
	// ----------------------------------------------------------------
	// Refresh wins over an access; nothing starts before boot decode locks
	assign take_rfs      = lock_q && (state_q == ST_IDLE) && refresh_req_in;
	assign take_req      = lock_q && (state_q == ST_IDLE) && !refresh_req_in && req_valid_in;
	assign req_ready_out = take_req;
	assign sel_w16       = (req_in.cs == `SB_BOOT_CS) ? boot_cfg_q.width16 : cs_width16_in[req_in.cs];
	assign strobe_done   = (cnt_q == `SB_STROBE_CYC - 3'h1);

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ST_IDLE;
			cnt_q   <= 3'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					cnt_q <= 3'h0;
					if (take_rfs) begin
						state_q <= ST_REFRESH;
					end else if (take_req) begin
						state_q <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					state_q <= ST_STROBE;
				end
				ST_STROBE: begin
					if (!strobe_done) begin
						cnt_q <= cnt_q + 3'h1;
					end else if (!(vlio_q && !rdy_s)) begin
						state_q <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					state_q <= ST_IDLE;
				end
				ST_REFRESH: begin
					if (cnt_q == `SB_REFRESH_CYC - 3'h1) begin
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 3'h1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Access capture and address pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			write_q <= 1'b0;
			vlio_q  <= 1'b0;
			w16_q   <= 1'b0;
			cs_q    <= 3'h0;
			addr_q  <= '0;
			wdata_q <= '0;
		end else if (take_req) begin
			write_q <= req_in.write;
			vlio_q  <= cs_vlio_in[req_in.cs];
			w16_q   <= sel_w16;
			cs_q    <= req_in.cs;
			wdata_q <= req_in.wdata;
			// Address bits below the bus width are driven at SB_HELD_BIT, so the pins do not toggle
			if (sel_w16) begin
				addr_q <= {req_in.addr[`SB_ADDR_W-1:1], `SB_HELD_BIT};
			end else begin
				addr_q <= {req_in.addr[`SB_ADDR_W-1:2], `SB_HELD_BIT, `SB_HELD_BIT};
			end
		end
	end

	assign addr_out = addr_q;
	assign data_out = wdata_q;

	// ----------------------------------------------------------------
	// Strobes
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cs_n_out              <= '1;
			oe_n_out              <= 1'b1;
			memory_write_strobe_n <= 1'b1;
			card_write_strobe_n   <= 1'b1;
			data_oe_n_out         <= 1'b1;
		end else begin
			cs_n_out              <= '1;
			oe_n_out              <= 1'b1;
			memory_write_strobe_n <= 1'b1;
			card_write_strobe_n   <= 1'b1;
			data_oe_n_out         <= 1'b1;
			if (take_rfs || (state_q == ST_REFRESH && cnt_q != `SB_REFRESH_CYC - 3'h1)) begin
				memory_write_strobe_n <= 1'b0;
			end
			if (state_q == ST_SETUP || state_q == ST_STROBE) begin
				cs_n_out[cs_q] <= 1'b0;
				data_oe_n_out  <= !write_q;
				if (!write_q) begin
					oe_n_out <= 1'b0;
				end else if (vlio_q) begin
					card_write_strobe_n <= 1'b0;
				end else begin
					memory_write_strobe_n <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Completion
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q <= '0;
			rsp_q   <= 1'b0;
			rfd_q   <= 1'b0;
		end else begin
			rsp_q <= (state_q == ST_HOLD);
			rfd_q <= (state_q == ST_REFRESH) && (cnt_q == `SB_REFRESH_CYC - 3'h1);
			if (state_q == ST_HOLD && !write_q) begin
				rdata_q <= data_s;
			end
		end
	end

	assign rsp_valid_out    = rsp_q;
	assign rsp_rdata_out    = rdata_q;
	assign refresh_done_out = rfd_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_boot_low;
		lock_q && code_q[2] == 1'b0 |-> boot_cfg_out.kind == (code_q[1] ? BOOT_SYNC_FLASH : BOOT_ASYNC_ROM)
			&& boot_cfg_out.width16 == code_q[0] && !boot_cfg_out.paired;
	endproperty
	a_boot_low: assert property (p_boot_low) else $error("Boot codes 0-3 decoded wrong");

	property p_boot_mrom32;
		lock_q && code_q == `SB_BOOT_MROM32 |-> boot_cfg_out.kind == BOOT_SYNC_MASK_ROM
			&& !boot_cfg_out.width16 && boot_cfg_out.capacity == `SB_CAP_64MBIT;
	endproperty
	a_boot_mrom32: assert property (p_boot_mrom32) else $error("Boot code 4 decoded wrong");

	property p_boot_mrom16;
		lock_q && code_q[2] && code_q[0] |-> boot_cfg_out.width16
			&& boot_cfg_out.capacity == (code_q[1] ? `SB_CAP_32MBIT : `SB_CAP_64MBIT);
	endproperty
	a_boot_mrom16: assert property (p_boot_mrom16) else $error("Boot codes 5 and 7 decoded wrong");

	property p_boot_pair;
		lock_q && code_q == `SB_BOOT_MROMPAIR |-> boot_cfg_out.paired && !boot_cfg_out.width16
			&& boot_cfg_out.capacity == `SB_CAP_64MBIT;
	endproperty
	a_boot_pair: assert property (p_boot_pair) else $error("Boot code 6 decoded wrong");

	property p_addr16;
		take_req && sel_w16 |=> addr_out[0] == 1'b0 && addr_out[`SB_ADDR_W-1:1] == $past(req_in.addr[`SB_ADDR_W-1:1]);
	endproperty
	a_addr16: assert property (p_addr16) else $error("Address bit 0 moved on 16-bit bus");

	property p_addr32;
		cs_n_out != '1 && !w16_q |-> addr_out[1:0] == 2'h0;
	endproperty
	a_addr32: assert property (p_addr32) else $error("Address bits 1:0 moved on 32-bit bus");

	property p_vlio_wait;
		state_q == ST_STROBE && strobe_done && vlio_q && !rdy_s |=> state_q == ST_STROBE && cs_n_out[cs_q] == 1'b0;
	endproperty
	a_vlio_wait: assert property (p_vlio_wait) else $error("VLIO strobe ended while not ready");

	property p_refresh_we;
		take_rfs |=> !memory_write_strobe_n [*4] ##1 memory_write_strobe_n && card_write_strobe_n;
	endproperty
	a_refresh_we: assert property (p_refresh_we) else $error("Refresh did not use memory write strobe");

	property p_vlio_write;
		!card_write_strobe_n |-> memory_write_strobe_n && $past(vlio_q) && $past(write_q);
	endproperty
	a_vlio_write: assert property (p_vlio_write) else $error("Card strobe outside VLIO write");

	property p_boot_hold;
		lock_q && $past(lock_q) |-> $stable(boot_cfg_out);
	endproperty
	a_boot_hold: assert property (p_boot_hold) else $error("Boot decode changed after lock");
endmodule
`default_nettype wire

// ==== sim/static_bus_mem_model.sv ====
// Behavioural static memory or VLIO device on the far side of the bus engine
`timescale 1ns/1ps
`default_nettype none
module static_bus_mem_model (
	input  wire logic        clk_in,          // System clock
	input  wire logic [25:0] addr_in,         // Address pins
	input  wire logic [5:0]  cs_n_in,         // Chip selects, active low
	input  wire logic        oe_n_in,         // Read strobe, active low
	input  wire logic        mem_we_n_in,     // Memory write strobe
	input  wire logic        card_we_n_in,    // Card write strobe
	input  wire logic        data_oe_n_in,    // Engine drives data when low
	input  wire logic [31:0] wdata_in,        // Data from the engine
	input  wire logic [3:0]  wait_cycles_in,  // Not-ready cycles per access
	output logic      [31:0] rdata_out,       // Data back to the engine
	output logic             rdy_out          // Ready, high when ready
);
	logic [31:0] mem_q [16];
	logic [31:0] last_q = 32'h0;
	logic [3:0]  wait_q = 4'h0;
	logic        sel;

	assign sel = ~&cs_n_in;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Write strobes count only while selected, so refresh strobes never write
	always_ff @(posedge clk_in) begin
		if (sel && !data_oe_n_in && (!mem_we_n_in || !card_we_n_in)) begin
			mem_q[addr_in[5:2]] <= wdata_in;
		end
		if (sel && !oe_n_in) begin
			last_q <= mem_q[addr_in[5:2]];
		end
	end

	// ----------------------------------------------------------------
	// Ready and data return
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!sel) begin
			wait_q <= wait_cycles_in;
		end else if (wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
		end
	end

	assign rdy_out = (wait_q == 4'h0);
	// Released data lines show the inverse of the last word, never a stale copy
	assign rdata_out = (sel && !oe_n_in) ? mem_q[addr_in[5:2]] : ~last_q;
endmodule
`default_nettype wire

// ==== sim/test_static_bus_ctrl.sv ====
// Self-checking testbench for the static memory bus engine
`timescale 1ns/1ps
`default_nettype none
`include "static_bus_defs.svh"
module test_static_bus_ctrl;
	import static_bus_pkg::*;

	typedef struct {
		logic        write;
		logic [2:0]  cs;
		logic [25:0] addr;
		logic [31:0] wdata;
		logic [3:0]  wait_n;
		logic [1:0]  exp_low;
		int          len_min;
		int          len_max;
		logic [31:0] exp_rdata;
	} row_s;

	logic        clk, rst_n, rdy, req_valid, req_ready, refresh_req, refresh_done;
	logic        rsp_valid, boot_valid, oe_n, mws_n, cws_n, data_oe_n;
	logic [2:0]  boot_sel;
	logic [5:0]  cs_vlio, cs_w16, cs_n, cs_seen;
	logic [25:0] addr, addr_seen;
	logic [31:0] rsp_rdata, data_in, data_out;
	logic [3:0]  wait_n;
	bus_req_s    req;
	boot_cfg_s   boot_cfg;
	int          mismatches, n_tests, n_mws, n_cws, n_oe, k, taken;

	row_s rows [9] = '{
		'{1'b1, 3'h1, 26'h3FF_FFFF, 32'h1234_5678, 4'h0, 2'h0, 3, 3, 32'h0},
		'{1'b0, 3'h1, 26'h3FF_FFFF, 32'h0, 4'h0, 2'h0, 3, 3, 32'h1234_5678},
		'{1'b1, 3'h2, 26'h000_0003, 32'hCAFE_0001, 4'h0, 2'h2, 3, 3, 32'h0},
		'{1'b1, 3'h3, 26'h000_0005, 32'h5555_AAAA, 4'h0, 2'h0, 3, 3, 32'h0},
		'{1'b1, 3'h3, 26'h000_0006, 32'h0F0F_F0F0, 4'h5, 2'h0, 6, 10, 32'h0},
		'{1'b0, 3'h3, 26'h000_0007, 32'h0, 4'h5, 2'h0, 6, 10, 32'h0F0F_F0F0},
		'{1'b1, 3'h4, 26'h000_000B, 32'h8765_4321, 4'h5, 2'h2, 3, 3, 32'h0},
		'{1'b0, 3'h0, 26'h000_0007, 32'h0, 4'h3, 2'h2, 3, 3, 32'h0F0F_F0F0},
		'{1'b0, 3'h2, 26'h000_0009, 32'h0, 4'h0, 2'h0, 3, 3, 32'h8765_4321}
	};

	static_bus_ctrl i_static_bus_ctrl (
		.clk_in(clk), .rst_n_in(rst_n), .boot_sel_in(boot_sel), .rdy_in(rdy),
		.cs_vlio_in(cs_vlio), .cs_width16_in(cs_w16), .req_valid_in(req_valid), .req_in(req),
		.req_ready_out(req_ready), .refresh_req_in(refresh_req), .refresh_done_out(refresh_done),
		.rsp_valid_out(rsp_valid), .rsp_rdata_out(rsp_rdata), .boot_cfg_out(boot_cfg),
		.boot_valid_out(boot_valid), .addr_out(addr), .cs_n_out(cs_n), .oe_n_out(oe_n),
		.memory_write_strobe_n(mws_n), .card_write_strobe_n(cws_n), .data_in(data_in),
		.data_out(data_out), .data_oe_n_out(data_oe_n)
	);

	static_bus_mem_model i_static_bus_mem_model (
		.clk_in(clk), .addr_in(addr), .cs_n_in(cs_n), .oe_n_in(oe_n), .mem_we_n_in(mws_n),
		.card_we_n_in(cws_n), .data_oe_n_in(data_oe_n), .wdata_in(data_out),
		.wait_cycles_in(wait_n), .rdata_out(data_in), .rdy_out(rdy)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Pin monitor, sampled mid-cycle where outputs are settled
	// ----------------------------------------------------------------
	always @(negedge clk) begin
		if (mws_n === 1'b0) n_mws++;
		if (cws_n === 1'b0) n_cws++;
		if (oe_n === 1'b0) n_oe++;
		if (cs_n !== 6'h3F) begin
			cs_seen = cs_n;
			addr_seen = addr;
		end
	end

	// ----------------------------------------------------------------
	// Compare and report
	// ----------------------------------------------------------------
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_cfg(input boot_cfg_s got, input boot_cfg_s exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_len(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask

	// A bound that runs out is a failure and ends the run
	task automatic bound_hit(input int lim);
		if (k >= lim) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, k, lim);
			complete_run();
		end
	endtask

	function automatic boot_cfg_s exp_cfg(input logic [2:0] c);
		boot_cfg_s e;
		e.kind = c < 3'h2 ? BOOT_ASYNC_ROM : (c < 3'h4 ? BOOT_SYNC_FLASH : BOOT_SYNC_MASK_ROM);
		e.width16 = c[0];
		e.paired = (c == `SB_BOOT_MROMPAIR);
		e.capacity = c < 3'h4 ? `SB_CAP_NONE : (c == `SB_BOOT_MROM16S ? `SB_CAP_32MBIT : `SB_CAP_64MBIT);
		return e;
	endfunction

	task automatic clear_mon;
		n_mws = 0;
		n_cws = 0;
		n_oe = 0;
		cs_seen = 6'h3F;
	endtask

	// ----------------------------------------------------------------
	// Reset with a boot code, then check the locked decode
	// ----------------------------------------------------------------
	task automatic do_reset(input logic [2:0] code);
		@(posedge clk);
		rst_n <= 1'b0;
		boot_sel <= code;
		repeat (12) @(posedge clk);
		chk_val(32'({cs_n, oe_n, mws_n, cws_n, data_oe_n, boot_valid}), 32'h0000_07FE);
		rst_n <= 1'b1;
		k = 0;
		do begin @(negedge clk); k++; end while (boot_valid !== 1'b1 && k < 10);
		bound_hit(10);
		chk_cfg(boot_cfg, exp_cfg(code));
		@(posedge clk);
		boot_sel <= ~code;
		repeat (6) @(posedge clk);
		chk_cfg(boot_cfg, exp_cfg(code));
		$display("boot code %0d done", code);
	endtask

	// ----------------------------------------------------------------
	// One access: hold the request until taken, then watch the pins
	// ----------------------------------------------------------------
	task automatic access(input row_s r);
		int sel;
		@(posedge clk);
		clear_mon();
		req_valid <= 1'b1;
		req <= '{r.write, r.cs, r.addr, r.wdata};
		wait_n <= r.wait_n;
		k = 0;
		do begin @(negedge clk); k++; end while (req_ready !== 1'b1 && k < 20);
		bound_hit(20);
		@(posedge clk);
		req_valid <= 1'b0;
		k = 0;
		do begin @(negedge clk); k++; end while (rsp_valid !== 1'b1 && k < 60);
		bound_hit(60);
		sel = !r.write ? n_oe : (cs_vlio[r.cs] ? n_cws : n_mws);
		// Concatenation keeps the inversion at six bits, so no ones spill above the chip selects
		chk_val(32'(cs_seen), {26'h000_0000, ~(6'h01 << r.cs)});
		chk_val(32'(addr_seen), 32'({r.addr[25:2], r.exp_low}));
		chk_len(sel, r.len_min, r.len_max);
		chk_len(n_mws + n_cws + n_oe - sel, 0, 0);
		if (!r.write) chk_val(rsp_rdata, r.exp_rdata);
		$display("access cs %0d write %0d wait %0d done", r.cs, r.write, r.wait_n);
	endtask

	initial begin
		rst_n = 1'b0;
		boot_sel = 3'h0;
		cs_vlio = 6'h08;
		cs_w16 = 6'h14;
		req_valid = 1'b0;
		req = '0;
		refresh_req = 1'b0;
		wait_n = 4'h0;
		mismatches = 0;
		n_tests = 0;
		clear_mon();
		for (int c = 0; c < 8; c++) do_reset(3'(c));
		foreach (rows[i]) access(rows[i]);

		// Refresh under VLIO with an access waiting beside it
		@(posedge clk);
		cs_vlio <= 6'h3F;
		clear_mon();
		taken = 0;
		refresh_req <= 1'b1;
		req_valid <= 1'b1;
		req <= '{1'b1, 3'h3, 26'h000_0010, 32'hDEAD_BEEF};
		k = 0;
		do begin @(negedge clk); k++; if (req_ready === 1'b1) taken++; end while (n_mws == 0 && k < 20);
		bound_hit(20);
		@(posedge clk);
		refresh_req <= 1'b0;
		req_valid <= 1'b0;
		k = 0;
		do begin @(negedge clk); k++; end while (refresh_done !== 1'b1 && k < 20);
		bound_hit(20);
		chk_len(n_mws, 4, 4);
		chk_len(n_cws + taken, 0, 0);
		chk_val(32'(cs_seen), 32'h0000_003F);
		$display("refresh done");
		complete_run();
	end
endmodule
`default_nettype wire
